// [temp_status_id_registers_tb.sv]
// Self-checking bench of the thermal sensor register block.
`timescale 1ns/10ps
`default_nettype none
module temp_status_id_registers_tb;
  import tsr_pkg::*;
  localparam logic [6:0]  DEV  = 7'h2b;    // Arbitrary bus address.
  localparam logic [15:0] MAKR = 16'h7e3d; // Arbitrary value.
  localparam logic [7:0]  PART = 8'h4a;    // Arbitrary value.
  localparam logic [7:0]  REV  = 8'h06;    // Arbitrary value.
  logic        clk, reset_n, scl, pull, sda, sda_out, sda_oe, conv_valid, a;
  logic [11:0] temp_code, t;
  logic [10:0] crit, upper, lower;
  logic [5:0]  hyst;
  logic [7:0]  ptr;
  logic [31:0] seed;
  tsr_word_t   exp_w, w;
  int          fails, check_count;
  logic [11:0] corner [11] = '{12'd640, 12'd617, 12'd616, 12'd481, 12'd457, 12'd456,
                               12'd480, 12'd80, 12'd79, 12'h800, 12'h7ff};
  // Released line floats high; either party can pull it low.
  assign sda = !(sda_oe || pull);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  tsr_regs_top #(.DEV_ADDR(DEV), .MAKER_ID(MAKR), .PART_ID(PART), .REV_ID(REV)) dut_u (
    .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .conv_valid(conv_valid), .temp_code(temp_code), .critical_limit_value(crit), .upper_limit_value(upper),
    .lower_limit_value(lower), .hyst_code(hyst), .pointer_value(ptr));
  tsr_host_model host_u (.clk(clk), .scl(scl), .pull(pull), .sda(sda));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Trip flags hold between the set and clear points; limits are twice as coarse.
  function automatic tsr_word_t exp_meas(tsr_word_t prev, logic [11:0] v);
    int ti, c, u;
    logic fc, fu;
    ti = $signed(v);
    c = 2 * $signed(crit);
    u = 2 * $signed(upper);
    fc = (ti >= c) ? 1'b1 : ((ti <= c - int'(hyst)) ? 1'b0 : prev[15]);
    fu = (ti > u) ? 1'b1 : ((ti <= u - int'(hyst)) ? 1'b0 : prev[14]);
    return {fc, fu, ti < 2 * $signed(lower), v, 1'b0};
  endfunction : exp_meas
  task automatic test_done();
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input tsr_word_t seen, input tsr_word_t exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Sends the low n bytes of q, highest first, each one acknowledged.
  task automatic send(input int n, input logic [31:0] q);
    logic k;
    for (int i = n - 1; i >= 0; i--) begin
      host_u.wbyte(q[8*i+:8], k);
      chk({15'h0, k}, 16'h0001);
    end
  endtask : send
  task automatic rd(input logic setp, input logic [7:0] p, output tsr_word_t v);
    logic [7:0] hi, lo;
    if (setp) begin
      host_u.cond(1'b0);
      send(2, {16'h0, DEV, 1'b0, p});
    end
    host_u.cond(1'b0);
    send(1, {24'h0, DEV, 1'b1});
    host_u.rbyte(1'b1, hi);
    host_u.rbyte(1'b0, lo);
    host_u.cond(1'b1);
    v = {hi, lo};
  endtask : rd
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    test_done();
  end
  initial begin
    {reset_n, conv_valid, temp_code, exp_w} = '0;
    {crit, upper, lower, hyst} = {11'h140, 11'h0f0, 11'h028, 6'h18};
    seed = 32'heac9a1c0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    host_u.tick(4);
    chk({8'h00, ptr}, 16'h0000);
    rd(1'b0, 8'h00, w);
    chk(w, 16'h0000);
    rd(1'b1, 8'h05, w);
    chk(w, 16'h0000);
    rd(1'b1, 8'h06, w);
    chk(w, MAKR);
    rd(1'b1, 8'h07, w);
    chk(w, {PART, REV});
    rd(1'b1, 8'h08, w);
    chk(w, 16'h0000);
    host_u.cond(1'b0);
    host_u.wbyte({DEV ^ 7'h01, 1'b0}, a);
    chk({15'h0, a}, 16'h0000);
    host_u.cond(1'b1);
    seed = lfsr(seed);
    host_u.cond(1'b0);
    send(4, {DEV, 1'b0, 8'h06, seed[15:0]});
    host_u.cond(1'b1);
    chk({8'h00, ptr}, 16'h0006);
    rd(1'b0, 8'h00, w);
    chk(w, MAKR);
    rd(1'b1, 8'h05, w);
    chk(w, 16'h0000);
    // Corner temperatures first, then random ones around the limits.
    for (int i = 0; i < 30; i++) begin
      seed = lfsr(seed);
      t = (i < 11) ? corner[i] : 12'(int'(seed % 800) - 100);
      @(negedge clk);
      // Every fifth random conversion also moves the limits and the band, so no limit input stays fixed.
      if (i >= 11 && i % 5 == 1) begin
        crit  = 11'(280 + seed[5:0]);
        upper = 11'(200 + seed[11:6]);
        lower = 11'(20 + seed[16:12]);
        hyst  = seed[22:17];
      end
      temp_code = t;
      conv_valid = 1'b1;
      @(negedge clk);
      conv_valid = 1'b0;
      exp_w = exp_meas(exp_w, t);
      rd(1'b0, 8'h00, w);
      chk(w, exp_w);
    end
    // A reset in mid-run must clear the latched pointer and the measurement word.
    reset_n = 1'b0;
    host_u.tick(2);
    reset_n = 1'b1;
    host_u.tick(4);
    chk({8'h00, ptr}, 16'h0000);
    rd(1'b1, 8'h05, w);
    chk(w, 16'h0000);
    test_done();
  end
endmodule : temp_status_id_registers_tb
`default_nettype wire

// [tsr_defines.svh]
// Constants for the thermal sensor register block: offsets, bit fields and reset values.
// Operation
// R1: Measurement register, read-only, at pointer 0x05.
// R2: Bits 12..1 two's complement, 0.125 degree LSB.
// R3: Bit 0 reserved, always reads zero.
// R4: Bit 15 critical flag, clears after hysteresis.
// R5: Bit 14 upper flag, clears after hysteresis.
// R6: Bit 13 lower flag, clears without hysteresis.
// R7: Flags follow comparisons only, not alarm pin.
// R8: Limits use bits 12..2, aligned with measurement.
// R9: Maker code register, read-only, at 0x06.
// R10: Part code high byte, revision low byte, 0x07.
// R11: Write: address, pointer, two data bytes, all acked.
// R12: Word read sends MSB first, ends on nack.
// R13: Pointer stays latched for repeated reads.
// R14: Master sets pointer then repeated start to read.
// R15: Writes to read-only registers acked, then discarded.
// R16: First data byte is bits 15..8, second 7..0.
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH

`define TSR_PTR_MEAS        8'h05
`define TSR_PTR_MAKER       8'h06
`define TSR_PTR_PART        8'h07
`define TSR_BIT_CRIT        15
`define TSR_BIT_UPPER       14
`define TSR_BIT_LOWER       13
`define TSR_TEMP_MSB        12
`define TSR_TEMP_LSB        1
`define TSR_MEAS_RESET      16'h0000
`define TSR_PTR_RESET       8'h00
`define TSR_BYTE_BITS       4'h8

`endif

// [tsr_host_model.sv]
// Bus master model that bit-bangs the 2-wire port.
`timescale 1ns/10ps
`default_nettype none
module tsr_host_model (
  input  wire logic clk,
  output logic      scl,
  output logic      pull,
  input  wire logic sda
);
  // Idle bus: clock high, data released to the pull-up.
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // Data moves only while the clock is low; the reply is read mid-high.
  task automatic bitx(input logic b, output logic r);
    scl = 1'b0;
    tick(2);
    pull = !b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda;
    tick(2);
  endtask : bitx
  // Start or stop: data flips while the clock is high.
  task automatic cond(input logic first);
    scl = 1'b0;
    tick(2);
    pull = first;
    tick(2);
    scl = 1'b1;
    tick(3);
    pull = !first;
    tick(3);
  endtask : cond
  // Byte out, bit 7 first, then the device's acknowledge.
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask : wbyte
  // Byte in, then acknowledge, or no acknowledge on the last one.
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(!mack, r);
  endtask : rbyte
endmodule : tsr_host_model
`default_nettype wire

// [tsr_meas_if.sv]
// Carrier between the 2-wire slave and the trip evaluator.
`timescale 1ns/10ps
`default_nettype none
interface tsr_meas_if;
  logic        conv_valid;  // One-cycle pulse: a new conversion is ready.
  logic [11:0] temp_code;   // Signed temperature, 0.125 degree units.
  logic [10:0] crit_lim;    // Critical limit, 0.25 degree units.
  logic [10:0] upper_lim;   // Upper limit, 0.25 degree units.
  logic [10:0] lower_lim;   // Lower limit, 0.25 degree units.
  logic [5:0]  hyst;        // Hysteresis, 0.125 degree units.
  logic [15:0] meas_word;   // Assembled measurement register.

  modport eval (input conv_valid, temp_code, crit_lim, upper_lim, lower_lim, hyst, output meas_word);
  modport feed (output conv_valid, temp_code, crit_lim, upper_lim, lower_lim, hyst, input meas_word);
endinterface : tsr_meas_if
`default_nettype wire

// [tsr_pkg.sv]
// Types shared by the thermal sensor register block.
package tsr_pkg;

  // One-hot states of the 2-wire slave.
  typedef enum logic [6:0] {
    TSR_IDLE  = 7'b0000001,
    TSR_ADDR  = 7'b0000010,
    TSR_ACK   = 7'b0000100,
    TSR_PTR   = 7'b0001000,
    TSR_WDATA = 7'b0010000,
    TSR_RDATA = 7'b0100000,
    TSR_MACK  = 7'b1000000
  } tsr_state_e;

  // Which byte the current acknowledge closes.
  typedef enum logic [1:0] {
    TSR_PH_ADDR = 2'h0,
    TSR_PH_PTR  = 2'h1,
    TSR_PH_DATA = 2'h2
  } tsr_phase_e;

  typedef logic [15:0] tsr_word_t;

  // Whole state of the slave.
  typedef struct packed {
    tsr_state_e st;
    tsr_phase_e ph;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] ptr;
    tsr_word_t  tx;
    logic       rw;
    logic       mack;
    logic       oe;
    logic       scl_q;
    logic       sda_q;
  } tsr_slave_s;

  // Whole state of the trip evaluator.
  typedef struct packed {
    tsr_word_t word;
  } tsr_trip_s;

endpackage : tsr_pkg

// [tsr_regs_chk.sv]
// Pin-timing checker of the thermal sensor register block.
`timescale 1ns/10ps
`default_nettype none
module tsr_regs_chk (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [7:0] pointer_value
);
  // The data pin is open drain: its driven value never leaves low.
  property p_od; @(posedge clk) disable iff (!reset_n) sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sda_out driven high");
  // Pointer leaves reset cleared.
  property p_ptr_rst; @(posedge clk) disable iff (!reset_n) $rose(reset_n) |-> pointer_value == 8'h00; endproperty
  a_ptr_rst: assert property (p_ptr_rst) else $error("pointer not cleared");
  // No acknowledge can be due before the first start, so the pin stays released.
  property p_oe_rst; @(posedge clk) disable iff (!reset_n) $rose(reset_n) |-> !sda_oe [*4]; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("pin driven after reset");
  // Driving starts just after a falling bus clock.
  property p_rise; @(posedge clk) disable iff (!reset_n)
    $rose(sda_oe) |-> !$past(scl_in) && ($past(scl_in, 2) || $past(scl_in, 3)); endproperty
  a_rise: assert property (p_rise) else $error("drive began off the clock fall");
  // Release also happens just after a falling bus clock.
  property p_fall; @(posedge clk) disable iff (!reset_n)
    $fell(sda_oe) |-> !$past(scl_in) && ($past(scl_in, 2) || $past(scl_in, 3)); endproperty
  a_fall: assert property (p_fall) else $error("release off the clock fall");
  // A bit the device sends holds while the bus clock is high.
  property p_stand; @(posedge clk) disable iff (!reset_n) scl_in && $past(scl_in) |-> $stable(sda_oe); endproperty
  a_stand: assert property (p_stand) else $error("data moved during clock high");
  // Late in a low phase the pin is settled already.
  property p_low; @(posedge clk) disable iff (!reset_n)
    !scl_in && !$past(scl_in) && !$past(scl_in, 2) && !$past(scl_in, 3) |-> $stable(sda_oe); endproperty
  a_low: assert property (p_low) else $error("data moved late in clock low");
  // An idle bus leaves the latched pointer alone.
  property p_ptr_idle; @(posedge clk) disable iff (!reset_n)
    scl_in && $past(scl_in) && sda_in && $past(sda_in) && $past(sda_in, 2) |-> $stable(pointer_value); endproperty
  a_ptr_idle: assert property (p_ptr_idle) else $error("pointer moved on idle bus");
endmodule : tsr_regs_chk
bind tsr_regs_top tsr_regs_chk chk_u (.clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .pointer_value(pointer_value));
`default_nettype wire

// [tsr_regs_top.sv]
// Top of the thermal sensor register block: 2-wire slave and register read mux.
`timescale 1ns/10ps
`default_nettype none
`include "tsr_defines.svh"
module tsr_regs_top #(
  parameter logic [6:0] DEV_ADDR  = 7'h18,  // Bus address; arbitrary value.
  parameter logic [15:0] MAKER_ID = 16'h5a5a, // Arbitrary value.
  parameter logic [7:0] PART_ID   = 8'h3c,  // Arbitrary value.
  parameter logic [7:0] REV_ID    = 8'h01   // Arbitrary value.
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        conv_valid,
  input  wire logic [11:0] temp_code,
  input  wire logic [10:0] critical_limit_value,
  input  wire logic [10:0] upper_limit_value,
  input  wire logic [10:0] lower_limit_value,
  input  wire logic [5:0]  hyst_code,
  output logic [7:0]       pointer_value
);
  import tsr_pkg::*;

  tsr_slave_s s_reg;        // Registered slave state.
  tsr_slave_s s_next;       // Next slave state.
  tsr_word_t  rd_word;      // Register selected by the pointer.
  logic       scl_rise;     // Clock line went high this cycle.
  logic       scl_fall;     // Clock line went low this cycle.
  logic       start_seen;   // Data fell while clock high.
  logic       stop_seen;    // Data rose while clock high.

  tsr_meas_if mif ();

  // Feed the evaluator straight from the ports.
  assign mif.conv_valid = conv_valid;
  assign mif.temp_code  = temp_code;
  assign mif.crit_lim   = critical_limit_value;
  assign mif.upper_lim  = upper_limit_value;
  assign mif.lower_lim  = lower_limit_value;
  assign mif.hyst       = hyst_code;

  tsr_trip_eval u_trip (
    .clk     (clk),
    .reset_n (reset_n),
    .m       (mif.eval)
  );

  // Bus edges; the pins are already synchronous to clk.
  assign scl_rise   = scl_in & ~s_reg.scl_q;
  assign scl_fall   = ~scl_in & s_reg.scl_q;
  assign start_seen = scl_in & s_reg.scl_q & s_reg.sda_q & ~sda_in;
  assign stop_seen  = scl_in & s_reg.scl_q & ~s_reg.sda_q & sda_in;

  // Read mux; unmapped pointers read as zero since those registers live elsewhere.
  always_comb begin
    unique case (s_reg.ptr)
      `TSR_PTR_MEAS:  rd_word = mif.meas_word; // R1
      `TSR_PTR_MAKER: rd_word = MAKER_ID; // R9
      `TSR_PTR_PART:  rd_word = {PART_ID, REV_ID}; // R10
      default:        rd_word = 16'h0000;
    endcase
  end

  // Slave sequencing: sample on rising clock edges, change the line on falling ones.
  always_comb begin
    s_next       = s_reg;
    s_next.scl_q = scl_in;
    s_next.sda_q = sda_in;
    if (start_seen) begin
      // A start or repeated start always restarts address reception.
      s_next.st  = TSR_ADDR;
      s_next.cnt = 4'h0;
      s_next.oe  = 1'b0;
    end else if (stop_seen) begin
      s_next.st = TSR_IDLE;
      s_next.oe = 1'b0;
    end else begin
      unique case (s_reg.st)
        TSR_IDLE: begin
          s_next.oe = 1'b0;
        end
        TSR_ADDR, TSR_PTR, TSR_WDATA: begin
          // Shift in one byte, most significant bit first.
          if (scl_rise) begin
            s_next.sh  = {s_reg.sh[6:0], sda_in};
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (scl_fall && s_reg.cnt == `TSR_BYTE_BITS) begin
            s_next.cnt = 4'h0;
            if (s_reg.st == TSR_ADDR) begin
              if (s_reg.sh[7:1] == DEV_ADDR) begin
                s_next.st = TSR_ACK; // R11
                s_next.oe = 1'b1;
                s_next.ph = TSR_PH_ADDR;
                s_next.rw = s_reg.sh[0];
                s_next.tx = rd_word; // R12
              end else begin
                // Another device is addressed: stay off the line.
                s_next.st = TSR_IDLE;
              end
            end else if (s_reg.st == TSR_PTR) begin
              s_next.ptr = s_reg.sh; // R13 R14
              s_next.st  = TSR_ACK; // R11
              s_next.oe  = 1'b1;
              s_next.ph  = TSR_PH_PTR;
            end else begin
              // Data bytes (high then low) are acked; every register here is read-only.
              s_next.st = TSR_ACK; // R11 R15 R16
              s_next.oe = 1'b1;
              s_next.ph = TSR_PH_DATA;
            end
          end
        end
        TSR_ACK: begin
          // Release the acknowledge and, for a read, put out the first data bit.
          if (scl_fall) begin
            s_next.oe = 1'b0;
            if (s_reg.ph == TSR_PH_ADDR && s_reg.rw) begin
              s_next.st = TSR_RDATA;
              s_next.oe = ~s_reg.tx[15]; // R12
              s_next.tx = {s_reg.tx[14:0], 1'b0};
            end else if (s_reg.ph == TSR_PH_ADDR) begin
              s_next.st = TSR_PTR;
            end else begin
              s_next.st = TSR_WDATA;
            end
          end
        end
        TSR_RDATA: begin
          // Open drain: pull low for a zero, let go for a one.
          if (scl_rise) begin
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (scl_fall) begin
            if (s_reg.cnt == `TSR_BYTE_BITS) begin
              s_next.cnt  = 4'h0;
              s_next.oe   = 1'b0;
              s_next.mack = 1'b0;
              s_next.st   = TSR_MACK;
            end else begin
              s_next.oe = ~s_reg.tx[15];
              s_next.tx = {s_reg.tx[14:0], 1'b0};
            end
          end
        end
        TSR_MACK: begin
          // Master acknowledge asks for the next byte; not-acknowledge ends the read.
          if (scl_rise) begin
            s_next.mack = ~sda_in;
            if (sda_in) begin
              s_next.st = TSR_IDLE; // R12
            end
          end else if (scl_fall && s_reg.mack) begin
            s_next.st = TSR_RDATA; // R12
            s_next.oe = ~s_reg.tx[15];
            s_next.tx = {s_reg.tx[14:0], 1'b0};
          end
        end
        default: begin
          s_next.st = TSR_IDLE;
          s_next.oe = 1'b0;
        end
      endcase
    end
  end

  // State register; idle lines are high, so the edge samples start high.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '{st: TSR_IDLE, ph: TSR_PH_ADDR, sh: 8'h00, cnt: 4'h0, ptr: `TSR_PTR_RESET,
                 tx: 16'h0000, rw: 1'b0, mack: 1'b0, oe: 1'b0, scl_q: 1'b1, sda_q: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  assign sda_out       = 1'b0;
  assign sda_oe        = s_reg.oe;
  assign pointer_value = s_reg.ptr;
endmodule : tsr_regs_top
`default_nettype wire

// [tsr_trip_eval.sv]
// Trip evaluator: builds the measurement register from each conversion.
`timescale 1ns/10ps
`default_nettype none
`include "tsr_defines.svh"
module tsr_trip_eval (
  input  wire logic clk,
  input  wire logic reset_n,
  tsr_meas_if.eval  m
);
  import tsr_pkg::*;

  tsr_trip_s   s_reg;           // Registered state.
  tsr_trip_s   s_next;          // Next state.
  logic signed [13:0] t_val;    // Temperature widened so sums cannot wrap.
  logic signed [13:0] crit_val; // Critical limit on the same scale.
  logic signed [13:0] up_val;   // Upper limit on the same scale.
  logic signed [13:0] lo_val;   // Lower limit on the same scale.
  logic signed [13:0] hyst_val; // Hysteresis on the same scale.
  logic critical_over_flag;
  logic upper_over_flag;
  logic lower_under_flag;

  // Limits gain a zero 0.125 bit so both sides compare bit for bit.
  assign t_val    = {{2{m.temp_code[11]}}, m.temp_code}; // R2
  assign crit_val = {{2{m.crit_lim[10]}}, m.crit_lim, 1'b0}; // R8
  assign up_val   = {{2{m.upper_lim[10]}}, m.upper_lim, 1'b0}; // R8
  assign lo_val   = {{2{m.lower_lim[10]}}, m.lower_lim, 1'b0}; // R8
  assign hyst_val = {8'h00, m.hyst};

  // Flags only change on a new conversion; the alarm pin is never consulted.
  always_comb begin
    s_next = s_reg;
    critical_over_flag = s_reg.word[`TSR_BIT_CRIT];
    upper_over_flag    = s_reg.word[`TSR_BIT_UPPER];
    lower_under_flag   = s_reg.word[`TSR_BIT_LOWER];
    if (m.conv_valid) begin
      // Set at or above the limit, release only below the hysteresis band.
      if (t_val >= crit_val) begin
        critical_over_flag = 1'b1; // R4
      end else if (t_val <= crit_val - hyst_val) begin
        critical_over_flag = 1'b0; // R4
      end
      // Set strictly above the limit, release below the hysteresis band.
      if (t_val > up_val) begin
        upper_over_flag = 1'b1; // R5
      end else if (t_val <= up_val - hyst_val) begin
        upper_over_flag = 1'b0; // R5
      end
      // Lower flag has no hysteresis at all.
      lower_under_flag = (t_val < lo_val); // R6
      s_next.word = {critical_over_flag, upper_over_flag, lower_under_flag, m.temp_code, 1'b0}; // R3 R7
    end
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '{word: `TSR_MEAS_RESET};
    end else begin
      s_reg <= s_next;
    end
  end

  assign m.meas_word = s_reg.word; // R1
endmodule : tsr_trip_eval
`default_nettype wire
